// >>> design/rnpc_ctrl.sv
`include "rnpc_params.svh"
module rnpc_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Board pins
  input wire logic reset_request_pin_i,
  output logic reset_request_pin_o,
  output logic reset_request_pin_oe_o,
  output logic reset_indicator_pin_o,
  input wire logic urgent_interrupt_pin_i,
  // Reset sources from the CPU
  input wire logic sw_reset_i,
  input wire logic wdt_reset_i,
  // Instruction strobes
  input wire logic end_of_init_i,
  input wire logic power_down_instr_i,
  // Configuration write of bid_reset_enable
  input wire logic bid_reset_wr_i,
  input wire logic bid_reset_wdata_i,
  // Status and events
  output logic bid_reset_enable_o,
  output logic core_reset_o,
  output logic nmi_trap_o,
  output logic power_down_o
);
  import rnpc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Timing constants
  // Low time that counts as a request, in cycles; shorter lows never reset
  localparam int FILT = `RNPC_FILT_CYC;
  // Length of the internal reset sequence, in cycles
  localparam int SEQ = `RNPC_SEQ_CYC;
  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    rnpc_state_t fsm;                      // Sequencer state
    logic [`RNPC_FILT_W-1:0] filt;         // Low-time counter
    logic [`RNPC_SEQ_W-1:0] seq;           // Sequence counter
    logic bid;                             // Bidirectional enable
    logic ind;                             // Indicator level
    logic nmi_q;                           // Previous urgent level
    logic trap;                            // Trap pulse
    logic pdn;                             // Power-down latched
  } rnpc_ctrl_t;
  rnpc_ctrl_t st;
  rnpc_ctrl_t next_st;
  logic rst_lvl;    // Synchronised reset pin
  logic nmi_lvl;    // Synchronised urgent pin
  logic hw_req;     // Filtered hardware request
  logic any_req;    // Any reset source
  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  rnpc_pin_sync u_rst_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(reset_request_pin_i),
    .level_o(rst_lvl)
  );
  rnpc_pin_sync u_nmi_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(urgent_interrupt_pin_i),
    .level_o(nmi_lvl)
  );
  // Request once low has lasted the filter length
  assign hw_req = (st.filt == FILT[`RNPC_FILT_W-1:0]);
  assign any_req = hw_req | sw_reset_i | wdt_reset_i;
  ////////////////////////////////////////////////////////////////////////////
  // Next state
  // Reset sources are hardware (filtered pin), software and watchdog; any of
  // them starts the sequence, after which the block waits for end-of-init.
  // In bidirectional mode the block holds the pin low itself during the
  // sequence, so a short board pulse ends up as long as the sequence.
  always_comb begin
    next_st = st;
    next_st.trap = 1'b0;
    next_st.nmi_q = nmi_lvl;
    // Count low time; our own drive is seen too, which holds the request
    if (rst_lvl) begin
      next_st.filt = '0;
    end else if (!hw_req) begin
      next_st.filt = st.filt + 1'b1;
    end
    // Falling urgent edge
    if (st.nmi_q && !nmi_lvl) begin
      next_st.trap = 1'b1;
    end
    unique case (st.fsm)
      RNPC_RUN: begin
        // Power-down only with urgent pin low
        if (power_down_instr_i && !nmi_lvl) begin
          next_st.pdn = 1'b1;
        end
        // Writes allowed before init only
        if (bid_reset_wr_i && !st.ind) begin
          next_st.bid = bid_reset_wdata_i;
        end
      end
      RNPC_SEQ: begin
        // Run full length regardless of request length
        if (st.seq == SEQ[`RNPC_SEQ_W-1:0] - 1'b1) begin
          next_st.fsm = RNPC_INIT;
        end else begin
          next_st.seq = st.seq + 1'b1;
        end
      end
      RNPC_INIT: begin
        // Configurable until end-of-init
        if (bid_reset_wr_i) begin
          next_st.bid = bid_reset_wdata_i;
        end
        if (end_of_init_i) begin
          next_st.ind = 1'b1;
          next_st.fsm = RNPC_RUN;
        end
      end
      default: next_st.fsm = RNPC_SEQ;
    endcase
    // Any reset restarts the sequence, indicator low, unless a hardware request stands during the sequence
    if (any_req && !(st.fsm == RNPC_SEQ && hw_req)) begin
      next_st.fsm = RNPC_SEQ;
      next_st.seq = '0;
      next_st.ind = 1'b0;
      next_st.pdn = 1'b0;
    end
    // Enable cleared as the sequence ends, not as it starts: the old value
    // must stand for the whole sequence so that the pin is driven low
    if (st.fsm == RNPC_SEQ && next_st.fsm == RNPC_INIT) begin
      next_st.bid = `RNPC_BID_RST;
      // Our own low drive lingers in the synchroniser for a few cycles;
      // restarting the count keeps it from restarting the sequence, while a
      // board that still holds the pin low is counted afresh
      next_st.filt = '0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '{fsm: RNPC_SEQ, filt: '0, seq: '0, bid: `RNPC_BID_RST, ind: 1'b0,
              nmi_q: 1'b1, trap: 1'b0, pdn: 1'b0};
    end else begin
      st <= next_st;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Outputs; enable active low drives pin low
  // Open-drain line: the value is always low, the enable decides
  assign reset_request_pin_o = 1'b0;
  // Pulled low only while enabled and the sequence runs
  assign reset_request_pin_oe_o = !(st.bid && st.fsm == RNPC_SEQ);
  // Low from any reset until end-of-init
  assign reset_indicator_pin_o = st.ind;
  // Current enable, as software sees it
  assign bid_reset_enable_o = st.bid;
  // Core held in reset while the sequence runs
  assign core_reset_o = (st.fsm == RNPC_SEQ);
  // One-cycle trap request
  assign nmi_trap_o = st.trap;
  // Power-down stays until the next reset
  assign power_down_o = st.pdn;
  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Indicator low while the sequence runs
  ind_low_seq_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.fsm == RNPC_SEQ) |-> !reset_indicator_pin_o) else $error("ind high in reset");
  // Indicator released only by end-of-init
  ind_rise_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(reset_indicator_pin_o) |-> $past(end_of_init_i)) else $error("ind rose early");
  // Every synchronised falling edge gives a trap
  trap_edge_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.nmi_q && !nmi_lvl) |=> nmi_trap_o) else $error("trap missed");
  // No trap without a falling edge
  trap_cause_a: assert property (@(posedge clk_i) disable iff (reset_i)
    nmi_trap_o |-> $past(st.nmi_q) && !$past(nmi_lvl)) else $error("bad trap");
  // Power-down taken with the urgent pin low
  pdn_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (power_down_instr_i && !nmi_lvl && st.fsm == RNPC_RUN && !any_req) |=> power_down_o)
    else $error("pdn not entered");
  // Power-down never taken with the urgent pin high
  pdn_high_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(power_down_o) |-> !$past(nmi_lvl)) else $error("pdn with nmi high");
  // Pin pulled low from the first cycle of a sequence that starts enabled
  bid_drive_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (bid_reset_enable_o && !core_reset_o) ##1 core_reset_o |-> !reset_request_pin_oe_o [*8])
    else $error("pin not driven");
  // Enable frozen once end-of-init has run
  bid_lock_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (reset_indicator_pin_o && !any_req) |=> $stable(bid_reset_enable_o))
    else $error("enable changed");
  // Enable cleared as each sequence ends
  bid_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(core_reset_o) |-> !bid_reset_enable_o) else $error("enable kept");
  // Enable, and so the drive, unchanged through the sequence
  bid_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (core_reset_o && $past(core_reset_o)) |-> $stable(bid_reset_enable_o))
    else $error("enable moved in sequence");
  // A sequence lasts at least eight cycles, however short the request
  seq_full_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(core_reset_o) |-> core_reset_o [*8]) else $error("seq short");
  // Thirteen low cycles outside the sequence always reset
  filt_req_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (!rst_lvl && !core_reset_o) [*8] ##1 (!rst_lvl && !core_reset_o) [*5]
    |=> core_reset_o) else $error("reset missed");
  // A two-cycle low never makes a request
  spike_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.fsm == RNPC_RUN && rst_lvl) ##1 !rst_lvl [*2] ##1 rst_lvl |-> !hw_req)
    else $error("spike passed");
  // Main scenarios
  cov_trap_c: cover property (@(posedge clk_i) nmi_trap_o);
  cov_pdn_c: cover property (@(posedge clk_i) $rose(power_down_o));
  cov_init_c: cover property (@(posedge clk_i) $rose(reset_indicator_pin_o));
  cov_bid_c: cover property (@(posedge clk_i) !reset_request_pin_oe_o);
  cov_hw_c: cover property (@(posedge clk_i) hw_req && st.fsm == RNPC_RUN);
endmodule : rnpc_ctrl

// >>> design/rnpc_params.svh
`ifndef RNPC_PARAMS_SVH
`define RNPC_PARAMS_SVH
// Clock period in picoseconds (125 MHz)
`define RNPC_CLK_PERIOD_PS 8000
// Spike filter: shortest pulse always passed, in ns
`define RNPC_PASS_NS 100
// Spike filter: longest pulse always ignored, in ns
`define RNPC_REJECT_NS 10
// Filter length in cycles: above reject time, at or below pass time (rounded down)
`define RNPC_FILT_CYC ((`RNPC_PASS_NS * 1000) / `RNPC_CLK_PERIOD_PS)
// Counter width for the filter
`define RNPC_FILT_W 4
// Length of the internal reset sequence in cycles
`define RNPC_SEQ_CYC 64
// Counter width for the sequence
`define RNPC_SEQ_W 7
// Reset values
`define RNPC_BID_RST 1'b0
`endif

// >>> design/rnpc_pin_sync.sv
`include "rnpc_params.svh"
module rnpc_pin_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Raw pin
  input wire logic pin_i,
  // Debounced level
  output logic level_o
);
  import rnpc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Three-stage chain; a change counts once stages two and three agree
  typedef struct packed {
    logic [2:0] chain;
    logic level;
  } rnpc_sync_t;
  rnpc_sync_t st;
  rnpc_sync_t next_st;
  // Shift and take agreeing value
  always_comb begin
    next_st = st;
    next_st.chain = {st.chain[1:0], pin_i};
    if (st.chain[1] == st.chain[2]) begin
      next_st.level = st.chain[2];
    end
  end
  // Register, idle high
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '{chain: 3'h7, level: 1'b1};
    end else begin
      st <= next_st;
    end
  end
  assign level_o = st.level;
endmodule : rnpc_pin_sync

// >>> design/rnpc_pkg.sv
package rnpc_pkg;
  // Reset sequencer states, one-hot
  typedef enum logic [2:0] {
    RNPC_RUN = 3'b001,
    RNPC_SEQ = 3'b010,
    RNPC_INIT = 3'b100
  } rnpc_state_t;
endpackage : rnpc_pkg

// >>> test/reset_nmi_powerdown_ctrl_tb.sv
module reset_nmi_powerdown_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, reset_i = 1'b1, sw = 1'b0, wdt = 1'b0, eoi = 1'b0;
  logic pdi = 1'b0, bwr = 1'b0, bwd = 1'b0;
  logic rst_pin, urg_pin, rq_o, rq_oe, ind, bid, core, trap, pdn;
  int err_count = 0, tests_run = 0;
  initial forever #4 clk_i = ~clk_i;
  rnpc_board u_board (.clk_i(clk_i), .dev_oe_i(rq_oe), .dev_val_i(rq_o),
    .rst_pin_o(rst_pin), .urg_pin_o(urg_pin));
  rnpc_ctrl u_rnpc_ctrl (.clk_i(clk_i), .reset_i(reset_i), .reset_request_pin_i(rst_pin),
    .reset_request_pin_o(rq_o), .reset_request_pin_oe_o(rq_oe),
    .reset_indicator_pin_o(ind), .urgent_interrupt_pin_i(urg_pin), .sw_reset_i(sw),
    .wdt_reset_i(wdt), .end_of_init_i(eoi), .power_down_instr_i(pdi),
    .bid_reset_wr_i(bwr), .bid_reset_wdata_i(bwd), .bid_reset_enable_o(bid),
    .core_reset_o(core), .nmi_trap_o(trap), .power_down_o(pdn));
  ////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check
  // Wait bounded for core reset to reach a level
  task automatic wait_core(input logic v, input int n);
    while (core !== v && n > 0) begin
      @(negedge clk_i);
      n--;
    end
  endtask : wait_core
  // Finish sequence, then end-of-init pulse
  task automatic finish_init();
    wait_core(1'b0, 200);
    check("indicator before init", ind, 1'b0);
    eoi = 1'b1;
    @(negedge clk_i);
    eoi = 1'b0;
    @(negedge clk_i);
    check("indicator after init", ind, 1'b1);
  endtask : finish_init
  // One-cycle strobe on bid write
  task automatic bid_write(input logic v);
    bwr = 1'b1;
    bwd = v;
    @(negedge clk_i);
    bwr = 1'b0;
    @(negedge clk_i);
  endtask : bid_write
  // Software or watchdog reset
  task automatic t_soft(input bit use_wdt);
    if (use_wdt) wdt = 1'b1;
    else sw = 1'b1;
    @(negedge clk_i);
    {sw, wdt} = 2'b00;
    wait_core(1'b1, 5);
    check("soft reset core", core, 1'b1);
    check("soft reset indicator", ind, 1'b0);
    finish_init();
    $display("soft reset test done");
  endtask : t_soft
  ////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // Watchdog: the run needs about 400 cycles; 12,500 cycles means a hang
  initial begin
    #100000;
    err_count++;
    results();
  end
  ////////////////////////////////////////////////////////////////////
  // Enable written during init, then locked by end-of-init
  task automatic t_bid_lock();
    check("core in reset", core, 1'b1);
    check("pin released, enable clear", rq_oe, 1'b1);
    wait_core(1'b0, 200);
    bid_write(1'b1);
    check("bid set before init", bid, 1'b1);
    finish_init();
    bid_write(1'b0);
    check("bid locked", bid, 1'b1);
    $display("enable lock test done");
  endtask : t_bid_lock
  // Short lows on the reset line never reset
  task automatic t_spike();
    u_board.pulse_low(1);
    repeat (20) @(negedge clk_i);
    check("spike ignored", core, 1'b0);
    u_board.pulse_low(2);
    repeat (20) @(negedge clk_i);
    check("short low ignored", core, 1'b0);
    $display("spike test done");
  endtask : t_spike
  // Long low with bidirectional mode on: reset, drive, stretch
  task automatic t_hw();
    u_board.pulse_low(16);
    wait_core(1'b1, 20);
    check("long low resets", core, 1'b1);
    check("hw reset indicator", ind, 1'b0);
    repeat (40) @(negedge clk_i);
    check("short request stretched", core, 1'b1);
    check("pin driven in sequence", rq_oe, 1'b0);
    check("pin drive value", rq_o, 1'b0);
    check("line held low", rst_pin, 1'b0);
    finish_init();
    check("pin released after sequence", rq_oe, 1'b1);
    check("bid cleared by reset", bid, 1'b0);
    $display("hardware reset test done");
  endtask : t_hw
  // Falling urgent edge gives exactly one trap pulse
  task automatic t_trap();
    int pulses;
    pulses = 0;
    u_board.set_urg(1'b0);
    repeat (3) @(negedge clk_i);
    check("trap not early", trap, 1'b0);
    repeat (8) begin
      if (trap === 1'b1) pulses++;
      @(negedge clk_i);
    end
    check("one trap pulse", pulses == 1, 1'b1);
    $display("urgent edge test done");
  endtask : t_trap
  // Power-down refused with the pin high, taken with it low
  task automatic t_pdn();
    u_board.set_urg(1'b1);
    repeat (6) @(negedge clk_i);
    pdi = 1'b1;
    @(negedge clk_i);
    pdi = 1'b0;
    repeat (3) @(negedge clk_i);
    check("no power-down when high", pdn, 1'b0);
    check("still running", core, 1'b0);
    u_board.set_urg(1'b0);
    repeat (6) @(negedge clk_i);
    pdi = 1'b1;
    @(negedge clk_i);
    pdi = 1'b0;
    repeat (3) @(negedge clk_i);
    check("power-down when low", pdn, 1'b1);
    $display("power-down test done");
  endtask : t_pdn
  ////////////////////////////////////////////////////////////////////
  // Scenario order
  initial begin
    repeat (20) @(negedge clk_i);
    reset_i = 1'b0;
    t_bid_lock();
    t_spike();
    t_hw();
    t_soft(1'b0);
    t_soft(1'b1);
    t_trap();
    t_pdn();
    results();
  end
endmodule : reset_nmi_powerdown_ctrl_tb

// >>> test/rnpc_board.sv
////////////////////////////////////////////////////////////////////
// Board model: pulled-up reset line and urgent interrupt source
module rnpc_board (
  // Clock
  input wire logic clk_i,
  // Device side of the reset line
  input wire logic dev_oe_i,
  input wire logic dev_val_i,
  // Line levels
  output logic rst_pin_o,
  output logic urg_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold_low = 1'b0; // Board pulls reset low
  // Pull-up wins unless someone pulls low
  assign rst_pin_o = (hold_low || (!dev_oe_i && !dev_val_i)) ? 1'b0 : 1'b1;
  initial urg_pin_o = 1'b1;
  // Low pulse of n cycles on the reset line
  task automatic pulse_low(input int n);
    @(negedge clk_i);
    hold_low = 1'b1;
    repeat (n) @(negedge clk_i);
    hold_low = 1'b0;
  endtask : pulse_low
  // Urgent pin level
  task automatic set_urg(input logic v);
    @(negedge clk_i);
    urg_pin_o = v;
  endtask : set_urg
endmodule : rnpc_board
